/* hw/fetch_cache_mem.v */
`timescale 1ns/1ps
`include "spi_fetch_map.vh"
module fetch_cache_mem (
  input  wire                   i_clock,
  input  wire                   i_clock_enable,
  input  wire                   i_wr_en,
  input  wire [`CACHE_AW-1:0]   i_wr_addr,
  input  wire [7:0]             i_wr_data,
  input  wire [`CACHE_AW-1:0]   i_rd_addr,
  output reg  [7:0]             o_rd_data
);
  reg [7:0] mem [0:(1<<`CACHE_AW)-1];

  // Registered read; contents need no reset since length gates use
  always @(posedge i_clock)
  begin
    if (i_clock_enable)
    begin
      if (i_wr_en)
        mem[i_wr_addr] <= i_wr_data;
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule

/* hw/pin_sync.v */
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             i_clock,
  input  wire             i_clock_enable,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // Two stages; first stage feeds only the second
  // Keeps sampling under reset so a strap read at release sees the real pin
  always @(posedge i_clock)
  begin
    if (i_reset || i_clock_enable)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

/* hw/spi_fetch_map.vh */
`ifndef SPI_FETCH_MAP_VH
`define SPI_FETCH_MAP_VH

// Flash read opcodes
`define OP_FAST_READ      8'h0B
`define OP_DUAL_READ      8'h3B

// Boot signature location and expected bytes
`define SIG_ADDR          16'hFFFA
`define SIG_BYTE0         8'h32
`define SIG_BYTE1         8'h44
`define SIG_BYTE2         8'h46
`define SIG_BYTE3         8'h55
`define SIG_LAST_INDEX    2'h3
`define BOOT_VECTOR       16'h0000

// Serial clock counts per phase
`define CMD_CLOCKS        6'h28
`define SINGLE_DATA_CLKS  6'h08
`define DUAL_DATA_CLKS    6'h04
`define BYTE_BITS         4'h8

// Cache geometry
`define CACHE_BYTES       6'h20
`define CACHE_AW          5

// Serial clock half periods in system clocks for each strap setting
`define HALF_SLOW         2'h2
`define HALF_FAST         2'h1

// Synchroniser depth for pins
`define SYNC_STAGES       2

`endif

/* hw/spi_flash_code_fetch.v */
`timescale 1ns/1ps
`include "spi_fetch_map.vh"
module spi_flash_code_fetch (
  input  wire        i_clock,
  input  wire        i_clock_enable,
  input  wire        i_reset,
  input  wire        i_dual_mode_enable,
  input  wire        i_fetch_req,
  input  wire [15:0] i_fetch_addr,
  input  wire        i_flash_serial_in,
  input  wire        i_flash_serial_out,
  output reg         o_fetch_ready,
  output reg  [7:0]  o_fetch_data,
  output reg         o_code_external,
  output reg         o_boot_done,
  output reg         o_fast_speed,
  output reg         o_flash_chip_sel_n,
  output reg         o_flash_sclk,
  output reg         o_flash_serial_out,
  output reg         o_flash_serial_out_oe
);
  // One-hot engine states
  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_SHIFT = 5'h02;
  localparam [4:0] S_HOLD  = 5'h04;
  localparam [4:0] S_END   = 5'h08;
  localparam [4:0] S_HIT   = 5'h10;

  reg  [4:0]  state_q;
  reg         strap_taken_q, booting_q, sig_ok_q, pend_q, dual_q, run_q;
  reg         byte_done_q, cache_wr_q;
  reg  [1:0]  boot_idx_q, phase_q, rise_pipe_q, data_pipe_q;
  reg  [15:0] req_addr_q, last_addr_q, base_q, cache_wr_addr_q;
  reg  [5:0]  len_q, clocks_left_q;
  reg  [39:0] tx_q;
  reg  [7:0]  rx_q;
  reg  [3:0]  rx_cnt_q;
  wire [1:0]  pins_sync, half;
  wire [7:0]  cache_rd_data;
  wire        tick, rise, fall, hit;
  wire [5:0]  data_clks;
  wire [15:0] cache_end;

  // Address lies inside the window described by base and length
  function in_cache;
    input [15:0] addr;
    input [15:0] base;
    input [5:0]  len;
    begin
      in_cache = ((addr - base) < {10'h000, len}); // Modulo 16 bits, window may wrap
    end
  endfunction

  // Expected signature byte by position
  function [7:0] sig_byte;
    input [1:0] idx;
    begin
      case (idx)
        2'h0:    sig_byte = `SIG_BYTE0;
        2'h1:    sig_byte = `SIG_BYTE1;
        2'h2:    sig_byte = `SIG_BYTE2;
        default: sig_byte = `SIG_BYTE3;
      endcase
    end
  endfunction

  // Both flash data pins cross from the flash side
  pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clock        (i_clock),
    .i_clock_enable (i_clock_enable),
    .i_reset        (i_reset),
    .i_async        ({i_flash_serial_in, i_flash_serial_out}),
    .o_sync         (pins_sync)
  );

  // Cache storage, indexed by low address bits, wraps naturally
  fetch_cache_mem u_cache (
    .i_clock        (i_clock),
    .i_clock_enable (i_clock_enable),
    .i_wr_en        (cache_wr_q),
    .i_wr_addr      (cache_wr_addr_q[`CACHE_AW-1:0]),
    .i_wr_data      (o_fetch_data),
    .i_rd_addr      (req_addr_q[`CACHE_AW-1:0]),
    .o_rd_data      (cache_rd_data)
  );

  // Serial clock timing
  assign half      = o_fast_speed ? `HALF_FAST : `HALF_SLOW;
  assign tick      = run_q && (phase_q == (half - 2'h1));
  assign rise      = tick && !o_flash_sclk;
  assign fall      = tick && o_flash_sclk;
  assign data_clks = dual_q ? `DUAL_DATA_CLKS : `SINGLE_DATA_CLKS;
  assign cache_end = base_q + {10'h000, len_q};
  assign hit       = in_cache(req_addr_q, base_q, len_q);

  // Strap capture one cycle after reset release, never under reset
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      strap_taken_q <= 1'b0;
      o_fast_speed  <= 1'b0;
    end
    else if (i_clock_enable && !strap_taken_q)
    begin
      strap_taken_q <= 1'b1;
      o_fast_speed  <= pins_sync[0];
    end
  end

  // Serial clock generator and shifter
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      phase_q               <= 2'h0;
      o_flash_sclk          <= 1'b0;
      run_q                 <= 1'b0;
      clocks_left_q         <= 6'h00;
      tx_q                  <= 40'h00_0000_0000;
      o_flash_serial_out    <= 1'b0;
      o_flash_serial_out_oe <= 1'b0;
    end
    else if (i_clock_enable)
    begin
      if (state_q == S_IDLE && pend_q && !hit && strap_taken_q)
      begin
        // Opcode, 24-bit address, dummy byte, all one bit per clock
        tx_q <= {(i_dual_mode_enable && !o_fast_speed) ? `OP_DUAL_READ : `OP_FAST_READ,
                 8'h00, req_addr_q, 8'h00};
        o_flash_serial_out    <= 1'b0; // Both opcodes lead with a zero bit
        o_flash_serial_out_oe <= 1'b1;
        clocks_left_q <= `CMD_CLOCKS + ((i_dual_mode_enable && !o_fast_speed) ?
                         `DUAL_DATA_CLKS : `SINGLE_DATA_CLKS);
        run_q   <= 1'b1;
        phase_q <= 2'h0;
      end
      else if (state_q == S_HOLD && pend_q && !run_q && req_addr_q == last_addr_q + 16'h0001)
      begin
        // One more byte, no command
        clocks_left_q <= data_clks;
        run_q   <= 1'b1;
        phase_q <= 2'h0;
      end
      else if (run_q)
      begin
        phase_q <= tick ? 2'h0 : phase_q + 2'h1;
        if (tick)
          o_flash_sclk <= ~o_flash_sclk;
        if (rise)
          clocks_left_q <= clocks_left_q - 6'h01;
        if (fall)
        begin
          if (clocks_left_q == 6'h00)
            run_q <= 1'b0;
          tx_q <= {tx_q[38:0], 1'b0};
          o_flash_serial_out <= tx_q[38];
          // Release data-out once the dummy byte is gone in dual mode
          if (dual_q && clocks_left_q <= `DUAL_DATA_CLKS)
            o_flash_serial_out_oe <= 1'b0;
        end
      end
      else if (state_q == S_END || state_q == S_IDLE)
      begin
        o_flash_serial_out_oe <= 1'b0;
        o_flash_serial_out    <= tx_q[39];
      end
    end
  end

  // Delayed rising-edge marks line up with the two-stage pin sync
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rise_pipe_q <= 2'h0;
      data_pipe_q <= 2'h0;
      rx_q        <= 8'h00;
      rx_cnt_q    <= 4'h0;
      byte_done_q <= 1'b0;
    end
    else if (i_clock_enable)
    begin
      rise_pipe_q <= {rise_pipe_q[0], rise};
      data_pipe_q <= {data_pipe_q[0], rise && clocks_left_q <= data_clks};
      byte_done_q <= 1'b0;
      if (rise_pipe_q[1] && data_pipe_q[1])
      begin
        if (dual_q)
        begin
          rx_q <= {rx_q[5:0], pins_sync[1], pins_sync[0]};
          rx_cnt_q <= rx_cnt_q + 4'h2;
        end
        else
        begin
          rx_q <= {rx_q[6:0], pins_sync[1]};
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
      else if (rx_cnt_q == `BYTE_BITS)
      begin
        rx_cnt_q    <= 4'h0;
        byte_done_q <= 1'b1;
      end
    end
  end

  // Request capture; processor requests only once external code runs
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pend_q     <= 1'b0;
      req_addr_q <= 16'h0000;
    end
    else if (i_clock_enable)
    begin
      if (!pend_q && booting_q && strap_taken_q && state_q != S_END)
      begin
        pend_q     <= 1'b1;
        req_addr_q <= `SIG_ADDR + {14'h0000, boot_idx_q};
      end
      else if (!pend_q && i_fetch_req && o_code_external && !booting_q)
      begin
        pend_q     <= 1'b1;
        req_addr_q <= i_fetch_addr;
      end
      else if (state_q == S_HIT || (state_q == S_SHIFT && byte_done_q))
        pend_q <= 1'b0;
    end
  end

  // Main fetch engine, boot probe and cache bookkeeping
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state_q            <= S_IDLE;
      booting_q          <= 1'b1;
      boot_idx_q         <= 2'h0;
      sig_ok_q           <= 1'b1;
      o_code_external    <= 1'b0;
      o_boot_done        <= 1'b0;
      o_fetch_ready      <= 1'b0;
      o_fetch_data       <= 8'h00;
      o_flash_chip_sel_n <= 1'b1;
      last_addr_q        <= 16'h0000;
      base_q             <= 16'h0000;
      len_q              <= 6'h00;
      dual_q             <= 1'b0;
      cache_wr_q         <= 1'b0;
      cache_wr_addr_q    <= 16'h0000;
    end
    else if (i_clock_enable)
    begin
      o_fetch_ready <= 1'b0;
      cache_wr_q    <= 1'b0;
      case (state_q)
        S_IDLE:
        begin
          o_flash_chip_sel_n <= 1'b1;
          if (pend_q && strap_taken_q)
          begin
            if (hit && !booting_q)
              state_q <= S_HIT;
            else
            begin
              o_flash_chip_sel_n <= 1'b0;
              dual_q  <= i_dual_mode_enable && !o_fast_speed;
              state_q <= S_SHIFT;
              if (req_addr_q != cache_end)
              begin
                base_q <= req_addr_q;
                len_q  <= 6'h00;
              end
            end
          end
        end
        S_HIT:
        begin
          // Cache read was issued last cycle, select stays high
          o_fetch_data  <= cache_rd_data;
          o_fetch_ready <= 1'b1;
          last_addr_q   <= req_addr_q;
          state_q       <= S_IDLE;
        end
        S_SHIFT:
        begin
          if (byte_done_q)
          begin
            o_fetch_data <= rx_q;
            last_addr_q  <= req_addr_q;
            if (booting_q)
            begin
              if (rx_q != sig_byte(boot_idx_q))
                sig_ok_q <= 1'b0;
              boot_idx_q <= boot_idx_q + 2'h1;
              if (boot_idx_q == `SIG_LAST_INDEX)
              begin
                // No flash reads back idle pin level and fails the match
                booting_q       <= 1'b0;
                o_boot_done     <= 1'b1;
                o_code_external <= sig_ok_q && (rx_q == sig_byte(boot_idx_q));
                o_flash_chip_sel_n <= 1'b1;
                base_q          <= `BOOT_VECTOR;
                len_q           <= 6'h00;
                state_q         <= S_END;
              end
              else
                state_q <= S_HOLD;
            end
            else
            begin
              o_fetch_ready   <= 1'b1;
              cache_wr_q      <= 1'b1;
              cache_wr_addr_q <= req_addr_q;
              if (len_q == `CACHE_BYTES)
                base_q <= base_q + 16'h0001;
              else
                len_q <= len_q + 6'h01;
              state_q <= S_HOLD;
            end
          end
        end
        S_HOLD:
        begin
          if (pend_q && !run_q)
          begin
            if (req_addr_q == last_addr_q + 16'h0001)
              state_q <= S_SHIFT;
            else
            begin
              o_flash_chip_sel_n <= 1'b1;
              state_q <= hit ? S_HIT : S_END; // Hit skips the idle turn
            end
          end
        end
        S_END:
        begin
          o_flash_chip_sel_n <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* tb/spi_fetch_monitor.sv */
`timescale 1ns/1ps
module spi_fetch_monitor (
  input wire        i_clock,
  input wire        i_reset,
  input wire        i_fetch_req,
  input wire [15:0] i_fetch_addr,
  input wire        o_fetch_ready,
  input wire        o_code_external,
  input wire        o_boot_done,
  input wire        o_fast_speed,
  input wire        o_flash_chip_sel_n,
  input wire        o_flash_sclk
);
  reg        pend_q;
  reg [15:0] last_q;
  // Engine frees itself with ready, so the cycle with ready may take
  wire       take = i_fetch_req && (!pend_q || o_fetch_ready) && o_code_external && o_boot_done;
  wire       seq  = take && (i_fetch_addr == last_q + 16'h0001);

  // Shadow of the request in flight, to know the previous address
  always @(posedge i_clock)
    if (i_reset)
      pend_q <= 1'b0;
    else if (take)
      pend_q <= 1'b1;
    else if (o_fetch_ready)
      pend_q <= 1'b0;
  always @(posedge i_clock)
    if (take)
      last_q <= i_fetch_addr;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  a_sclk_idle_cs: assert property (o_flash_chip_sel_n |-> !o_flash_sclk)
    else $error("serial clock moved while deselected");
  a_ready_pulse: assert property (o_fetch_ready |=> !o_fetch_ready)
    else $error("ready longer than one cycle");
  a_ready_bound: assert property (take |-> ##[1:400] o_fetch_ready)
    else $error("fetch never answered");
  a_rom_no_flash: assert property (o_boot_done && !o_code_external |-> o_flash_chip_sel_n)
    else $error("flash selected while running from rom");
  a_probe_start: assert property ($fell(i_reset) |-> ##[1:16] !o_flash_chip_sel_n)
    else $error("boot probe did not start");
  a_strap_hold: assert property ($past(o_boot_done) |-> $stable(o_fast_speed))
    else $error("speed strap changed after boot");
  a_jump_ends: assert property (take && !seq && !o_flash_chip_sel_n |-> ##[1:8] o_flash_chip_sel_n)
    else $error("jump did not end transaction");
  a_seq_holds: assert property (seq && !o_flash_chip_sel_n |=> !o_flash_chip_sel_n [*4])
    else $error("sequential fetch dropped select");
  a_ext_after_probe: assert property (o_code_external |-> o_boot_done)
    else $error("external code before probe end");

  c_seq: cover property (seq);
  c_jump: cover property (take && !seq);
  c_rom: cover property (o_boot_done && !o_code_external);
endmodule

/* tb/spi_flash_code_fetch_tb_top.sv */
`timescale 1ns/1ps
module spi_flash_code_fetch_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        dual = 1'b0;
  logic        req = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic        pull = 1'b0;
  logic        sig = 1'b1;
  wire         rdy, ext, done, fast, cs_n, sclk, dout, oe, din, pin;
  wire  [7:0]  data, f_op;
  wire  [23:0] f_addr;
  wire  [15:0] cmd_cnt;
  logic [7:0]  op_x;
  logic [7:0]  d;
  logic [15:0] c0;
  int          n, i, cyc;
  int          error_cnt = 0;
  int          n_checks = 0;
  // Rows: {kind, address}; kind 0 sequential, 1 new command, 2 cache hit
  logic [17:0] rows [9] = '{18'h10000, 18'h00001, 18'h00002, 18'h10100, 18'h00101,
                            18'h00102, 18'h20101, 18'h20100, 18'h10200};

  spi_flash_code_fetch dut_u (
    .i_clock(clk), .i_clock_enable(1'b1), .i_reset(rst), .i_dual_mode_enable(dual),
    .i_fetch_req(req), .i_fetch_addr(addr), .i_flash_serial_in(din),
    .i_flash_serial_out(pin), .o_fetch_ready(rdy), .o_fetch_data(data),
    .o_code_external(ext), .o_boot_done(done), .o_fast_speed(fast),
    .o_flash_chip_sel_n(cs_n), .o_flash_sclk(sclk), .o_flash_serial_out(dout),
    .o_flash_serial_out_oe(oe));
  spi_flash_model flash_u (
    .i_cs_n(cs_n), .i_sclk(sclk), .i_dev_out(dout), .i_dev_oe(oe), .i_sig_ok(sig),
    .i_pull_up(pull), .o_flash_in(din), .o_out_pin(pin), .o_opcode(f_op),
    .o_addr(f_addr), .o_cmd_cnt(cmd_cnt));

  always #50 clk = ~clk;

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end

  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic [7:0] exp_byte(input [15:0] a);
    exp_byte = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  // One-cycle request, then bounded wait for the answer
  task automatic fetch(input [15:0] a);
    req = 1'b1;
    addr = a;
    @(negedge clk) req = 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    d = data;
  endtask

  task automatic step(input [15:0] a, input [1:0] kind);
    c0 = cmd_cnt;
    fetch(a);
    chk("data", {24'h0, exp_byte(a)}, {24'h0, d});
    chk("commands", {16'h0, c0 + (kind == 2'h1)}, {16'h0, cmd_cnt});
    if (kind == 2'h1)
      chk("command", {op_x, 8'h00, a}, {f_op, f_addr});
    if (kind == 2'h2)
      chk("hit cycles", 32'h2, n);
  endtask

  task automatic boot(input s, input du, input ok);
    pull = s;
    dual = du;
    sig = ok;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task final_report;
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    op_x = 8'h0B;
    boot(1'b0, 1'b0, 1'b1);
    chk("external", 32'h1, ext);
    chk("speed", 32'h0, fast);
    chk("probe", {8'h0B, 24'h00FFFA}, {f_op, f_addr});
    for (i = 0; i < 9; i++)
      step(rows[i][15:0], rows[i][17:16]);
    // Run past the cache depth, then probe both sides of the window's lower edge
    for (i = 0; i < 35; i++)
      step(16'h0300 + i, {1'b0, i == 0});
    step(16'h0303, 2'h2);
    step(16'h0302, 2'h1);
    op_x = 8'h3B;
    boot(1'b0, 1'b1, 1'b1);
    step(16'h0400, 2'h1);
    step(16'h0401, 2'h0);
    op_x = 8'h0B;
    boot(1'b1, 1'b1, 1'b1);
    chk("speed", 32'h1, fast);
    step(16'h0500, 2'h1);
    boot(1'b0, 1'b0, 1'b0);
    chk("external", 32'h0, ext);
    c0 = cmd_cnt;
    fetch(16'h0000);
    chk("refused", 32'd500, n);
    chk("commands", {16'h0, c0}, {16'h0, cmd_cnt});
    final_report;
  end
endmodule

bind spi_flash_code_fetch spi_fetch_monitor mon_u (
  .i_clock(i_clock), .i_reset(i_reset), .i_fetch_req(i_fetch_req),
  .i_fetch_addr(i_fetch_addr), .o_fetch_ready(o_fetch_ready),
  .o_code_external(o_code_external), .o_boot_done(o_boot_done),
  .o_fast_speed(o_fast_speed), .o_flash_chip_sel_n(o_flash_chip_sel_n),
  .o_flash_sclk(o_flash_sclk));

/* tb/spi_flash_model.sv */
`timescale 1ns/1ps
`include "spi_fetch_map.vh"
module spi_flash_model (
  input  wire        i_cs_n,
  input  wire        i_sclk,
  input  wire        i_dev_out,
  input  wire        i_dev_oe,
  input  wire        i_sig_ok,
  input  wire        i_pull_up,
  output reg         o_flash_in,
  output wire        o_out_pin,
  output reg  [7:0]  o_opcode,
  output reg  [23:0] o_addr,
  output reg  [15:0] o_cmd_cnt
);
  reg [15:0] bits;
  reg [31:0] sh;
  reg        io0;
  reg        io0_en;
  reg [7:0]  b;
  int        k;

  // Content: signature only when a valid image is fitted
  function [7:0] mem_byte(input [15:0] a);
    case (a)
      16'hFFFA: mem_byte = i_sig_ok ? `SIG_BYTE0 : 8'h5F;
      16'hFFFB: mem_byte = i_sig_ok ? `SIG_BYTE1 : 8'h5E;
      16'hFFFC: mem_byte = i_sig_ok ? `SIG_BYTE2 : 8'h59;
      16'hFFFD: mem_byte = i_sig_ok ? `SIG_BYTE3 : 8'h58;
      default:  mem_byte = a[7:0] ^ a[15:8] ^ 8'h5A;
    endcase
  endfunction

  // Shared data-out pin: device, then flash, else the strap pull
  assign o_out_pin = i_dev_oe ? i_dev_out : (io0_en ? io0 : i_pull_up);

  initial
  begin
    o_flash_in = 1'b0;
    io0_en = 1'b0;
    o_cmd_cnt = 16'h0000;
  end

  // New frame on select
  always @(negedge i_cs_n)
    bits = 16'h0000;

  // Released lines: flip so a stale value cannot pass
  always @(posedge i_cs_n)
  begin
    o_flash_in = ~o_flash_in;
    io0_en = 1'b0;
  end

  // Opcode and 24-bit address, MSB first, sampled on rise
  always @(posedge i_sclk)
    if (!i_cs_n)
    begin
      sh = {sh[30:0], o_out_pin};
      bits = bits + 16'h0001;
      if (bits == 16'h0020)
      begin
        o_opcode = sh[31:24];
        o_addr = sh[23:0];
        o_cmd_cnt = o_cmd_cnt + 16'h0001;
      end
    end

  // Data after the dummy byte, changed on fall, address runs on
  always @(negedge i_sclk)
    if (!i_cs_n && bits >= 16'h0028)
    begin
      k = bits - 40;
      if (o_opcode == `OP_DUAL_READ)
      begin
        b = mem_byte(o_addr[15:0] + k / 4);
        o_flash_in = b[7 - 2 * (k % 4)];
        io0 = b[6 - 2 * (k % 4)];
        io0_en = 1'b1;
      end
      else
      begin
        b = mem_byte(o_addr[15:0] + k / 8);
        o_flash_in = b[7 - k % 8];
      end
    end
endmodule
